// *** drfs_pkg.sv ***
// Purpose: Shared constants and types for the display reset filter sequencer
// Assumes: 200 MHz internal clock
// Notes: Times kept in their own units, cycle counts derived from them
package drfs_pkg;
    localparam int CLK_MHZ = 200;
    localparam int REJECT_US = 5;
    localparam int FULL_US = 9;
    localparam int LOAD_MS = 5;
    localparam int BLANK_MS = 120;
    localparam int REJECT_CYC = REJECT_US * CLK_MHZ;
    localparam int FULL_CYC = FULL_US * CLK_MHZ;
    localparam int LOAD_CYC = LOAD_MS * 1000 * CLK_MHZ;
    localparam int BLANK_CYC = BLANK_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 25;
    localparam int NVM_WORDS = 4;
    localparam int NVM_AW = 2;
    localparam logic [7:0] ID0_RST = 8'h00;
    localparam logic [7:0] COMMON_V_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_BLANK = 3'b001,
        ST_HOLD = 3'b010,
        ST_LOAD = 3'b011,
        ST_SETTLE = 3'b100
    } drfs_state_t;

    typedef struct packed {
        logic [7:0] id_byte;
        logic [7:0] common_voltage_setting;
        logic [7:0] cfg_a;
        logic [7:0] cfg_b;
    } drfs_nvm_t;
endpackage

// *** drfs_filter.sv ***
// Purpose: Glitch filter on the active-low hardware reset pin
// Assumes: Pin synchronous to ref_clk_i
// Notes: Pulses under the reject width never reach the sequencer
`timescale 1ns/1ps
module drfs_filter (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic hw_reset_n_i,
    output logic reset_act_o
);
    logic [11:0] low_reg;
    logic [11:0] high_reg;

    // Width measured in oscillator cycles
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            low_reg <= 12'h000;
            high_reg <= 12'h000;
        end else if (!hw_reset_n_i) begin
            high_reg <= 12'h000;
            if (low_reg != 12'hfff) low_reg <= low_reg + 12'h001;
        end else begin
            low_reg <= 12'h000;
            if (high_reg != 12'hfff) high_reg <= high_reg + 12'h001;
        end
    end

    // Assert at reject width; release also needs a clean high run
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reset_act_o <= 1'b0;
        end else if (!hw_reset_n_i && low_reg == 12'(drfs_pkg::REJECT_CYC - 1)) begin
            reset_act_o <= 1'b1;
        end else if (hw_reset_n_i && high_reg == 12'(drfs_pkg::REJECT_CYC - 1)) begin
            reset_act_o <= 1'b0;
        end
    end

    short_rejected_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(reset_act_o) |-> $past(low_reg) == 12'(drfs_pkg::REJECT_CYC - 1))
        else $error("reset taken before reject width");
    long_taken_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        low_reg == 12'(drfs_pkg::FULL_CYC) |-> reset_act_o)
        else $error("long pulse not taken");
    spike_held_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reset_act_o && hw_reset_n_i && high_reg < 12'(drfs_pkg::REJECT_CYC - 2)
        |=> reset_act_o)
        else $error("spike released reset");
endmodule // drfs_filter

// *** drfs_top.sv ***
// Purpose: Reset filter and reset-cancel sequencer of a display controller
// Assumes: Host keeps its own waits after release
// Notes: Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module drfs_top #(
    parameter int LOAD_CYC = drfs_pkg::LOAD_CYC,
    parameter int BLANK_CYC = drfs_pkg::BLANK_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic hw_reset_n_i,
    input wire logic sleep_out_i,
    input wire drfs_pkg::drfs_nvm_t nvm_data_i,
    output logic [1:0] nvm_addr_o,
    output logic nvm_rd_o,
    output drfs_pkg::drfs_nvm_t regs_o,
    output logic blank_o,
    output logic blank_seq_o,
    output logic defaults_o,
    output logic ready_o,
    output logic in_reset_o
);
    ////////////////////////////////////////////////////////////////////////
    logic reset_act;
    drfs_pkg::drfs_state_t state_reg;
    logic [24:0] cnt_reg;
    logic [24:0] since_rel_reg;
    logic was_sleep_out_reg;
    logic [7:0] words_reg [drfs_pkg::NVM_WORDS];
    logic [24:0] seq_len_reg;

    // Filter release trails the pin by the reject width; settle absorbs it
    localparam int SETTLE_CYC = (LOAD_CYC > drfs_pkg::REJECT_CYC + 2)
        ? LOAD_CYC - drfs_pkg::REJECT_CYC - 2 : 0;

    // Cancel phase: after blanking, before normal running
    function automatic logic in_cancel(input drfs_pkg::drfs_state_t s);
        return s != drfs_pkg::ST_RUN && s != drfs_pkg::ST_BLANK;
    endfunction

    drfs_filter u_filter (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .hw_reset_n_i(hw_reset_n_i),
        .reset_act_o(reset_act)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= drfs_pkg::ST_RUN;
            cnt_reg <= 25'h0000000;
            was_sleep_out_reg <= 1'b0;
        end else begin
            case (state_reg)
                drfs_pkg::ST_RUN: begin
                    if (reset_act) begin
                        was_sleep_out_reg <= sleep_out_i;
                        cnt_reg <= 25'h0000000;
                        // Blank sequence only from sleep-out
                        state_reg <= sleep_out_i ? drfs_pkg::ST_BLANK : drfs_pkg::ST_HOLD;
                    end
                end
                drfs_pkg::ST_BLANK: begin
                    cnt_reg <= cnt_reg + 25'h0000001;
                    // Bounded by blank time even if pin released early
                    if (cnt_reg == 25'(BLANK_CYC - 1)) begin
                        state_reg <= drfs_pkg::ST_HOLD;
                    end
                end
                drfs_pkg::ST_HOLD: begin
                    cnt_reg <= 25'h0000000;
                    if (!reset_act) state_reg <= drfs_pkg::ST_LOAD;
                end
                drfs_pkg::ST_LOAD: begin
                    // A new reset during reload starts over from defaults
                    if (reset_act) begin
                        state_reg <= drfs_pkg::ST_HOLD;
                    end else if (cnt_reg == 25'(drfs_pkg::NVM_WORDS)) begin
                        state_reg <= drfs_pkg::ST_SETTLE;
                    end else begin
                        cnt_reg <= cnt_reg + 25'h0000001;
                    end
                end
                drfs_pkg::ST_SETTLE: begin
                    if (reset_act) begin
                        state_reg <= drfs_pkg::ST_HOLD;
                    end else if (since_rel_reg >= 25'(SETTLE_CYC)) begin
                        state_reg <= drfs_pkg::ST_RUN;
                    end
                end
                default: state_reg <= drfs_pkg::ST_RUN;
            endcase
        end
    end

    // Time since filtered release
    // Saturates so a long idle never wraps back into the cancel window
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || reset_act) begin
            since_rel_reg <= 25'h0000000;
        end else if (since_rel_reg != 25'h1ffffff) begin
            since_rel_reg <= since_rel_reg + 25'h0000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // NVM reload into register copies
    // One word a cycle, lowest address first
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            nvm_addr_o <= 2'h0;
            nvm_rd_o <= 1'b0;
        end else begin
            nvm_rd_o <= state_reg == drfs_pkg::ST_LOAD && !reset_act
                && cnt_reg < 25'(drfs_pkg::NVM_WORDS);
            nvm_addr_o <= cnt_reg[1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || state_reg == drfs_pkg::ST_HOLD) begin
            for (int i = 0; i < drfs_pkg::NVM_WORDS; i++) words_reg[i] <= 8'h00;
        end else if (nvm_rd_o) begin
            words_reg[nvm_addr_o] <= nvm_data_i[8*(3-int'(nvm_addr_o)) +: 8];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            regs_o <= {drfs_pkg::ID0_RST, drfs_pkg::COMMON_V_RST, 8'h00, 8'h00};
        end else begin
            regs_o <= {words_reg[0], words_reg[1], words_reg[2], words_reg[3]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            blank_o <= 1'b0;
            blank_seq_o <= 1'b0;
            defaults_o <= 1'b0;
            ready_o <= 1'b1;
            in_reset_o <= 1'b0;
        end else begin
            // Blank also covers the cycle where reset_act is set but the state is still ST_RUN
            blank_o <= state_reg != drfs_pkg::ST_RUN || reset_act;
            blank_seq_o <= state_reg == drfs_pkg::ST_BLANK;
            defaults_o <= state_reg == drfs_pkg::ST_HOLD;
            // Host still owes its own 5 ms and 120 ms waits
            ready_o <= state_reg == drfs_pkg::ST_RUN && !reset_act;
            in_reset_o <= reset_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Length of the blanking pulse as seen on the pin, checked below
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !blank_seq_o) begin
            seq_len_reg <= 25'h0000000;
        end else if (seq_len_reg != 25'h1ffffff) begin
            seq_len_reg <= seq_len_reg + 25'h0000001;
        end
    end

    // Checks on the sequencer
    sleepin_no_seq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == drfs_pkg::ST_RUN && reset_act && !sleep_out_i
        |=> state_reg == drfs_pkg::ST_HOLD)
        else $error("blank sequence run from sleep-in");
    sleepout_seq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == drfs_pkg::ST_RUN && reset_act && sleep_out_i
        |=> state_reg == drfs_pkg::ST_BLANK ##1 blank_seq_o)
        else $error("blank sequence not started from sleep-out");
    blank_bounded_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == drfs_pkg::ST_BLANK |-> cnt_reg < 25'(BLANK_CYC))
        else $error("blank sequence too long");
    seq_length_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        blank_seq_o |-> seq_len_reg < 25'(BLANK_CYC))
        else $error("blank output held too long");
    cancel_bounded_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        in_cancel(state_reg) && !reset_act && !was_sleep_out_reg
        |-> since_rel_reg < 25'(SETTLE_CYC + 8))
        else $error("reset cancel too long");
    cancel_sleepout_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        in_cancel(state_reg) && !reset_act && was_sleep_out_reg
        |-> since_rel_reg < 25'(BLANK_CYC + 8))
        else $error("sleep-out cancel too long");
    blank_held_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == drfs_pkg::ST_HOLD |=> blank_o)
        else $error("display not blank during reset");
    reload_done_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(reset_act) && state_reg == drfs_pkg::ST_HOLD |-> ##[1:8] nvm_rd_o)
        else $error("no reload after release");
    load_order_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        nvm_rd_o && nvm_addr_o != 2'h0
        |-> $past(nvm_rd_o) && $past(nvm_addr_o) == nvm_addr_o - 2'h1)
        else $error("reload words out of order");
    hold_release_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == drfs_pkg::ST_HOLD && !reset_act |=> state_reg == drfs_pkg::ST_LOAD)
        else $error("reload not started after release");
    rd_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg != drfs_pkg::ST_LOAD |=> !nvm_rd_o)
        else $error("read strobe outside reload");
    defaults_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == drfs_pkg::ST_HOLD |=> words_reg[1] == 8'h00)
        else $error("defaults not restored");
    defaults_out_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        defaults_o |=> regs_o == 32'h00000000)
        else $error("registers not at defaults");
endmodule // drfs_top

// *** drfs_host.sv ***
// Purpose: Host model driving the reset pin and sleep mode
// Assumes: Caller is at a falling clock edge
// Notes: Pin changes only at falling edges
`timescale 1ns/1ps
module drfs_host (
    input wire logic ref_clk_i,
    output logic hw_reset_n_o,
    output logic sleep_out_o
);
    initial begin
        hw_reset_n_o = 1'b1; // Dedicated pin, idle high
        sleep_out_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Full resets keep the pin low for at least 2000 cycles, i.e. 10us
    task automatic drive(input logic lvl, input int n, input logic slp);
        hw_reset_n_o = lvl;
        sleep_out_o = slp;
        repeat (n) @(negedge ref_clk_i);
    endtask
endmodule // drfs_host

// *** tb_drfs_top.sv ***
// Purpose: Self-checking bench for the reset filter sequencer
// Assumes: Short load and blank counts
// Notes: Host waits for ready before the next reset
`timescale 1ns/1ps
module tb_drfs_top;
    localparam int LOAD = 40;
    localparam int BLANK = 60;
    localparam drfs_pkg::drfs_nvm_t NVM = 32'ha53c690f;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_reset_n, sleep_out, nvm_rd, blank, blank_seq, defaults, ready, in_reset;
    logic [1:0] nvm_addr;
    drfs_pkg::drfs_nvm_t regs;
    int error_cnt = 0;
    int checks_done = 0;
    int rst_rises = 0;
    int seq_rises = 0;
    int rd_cnt = 0;
    int addr_bad = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    always @(posedge in_reset) rst_rises++;
    always @(posedge blank_seq) seq_rises++;
    always @(posedge ref_clk_i) begin
        if (nvm_rd === 1'b1) begin
            if (nvm_addr !== 2'(rd_cnt)) addr_bad++;
            rd_cnt++;
        end
    end
    drfs_host host (.ref_clk_i(ref_clk_i), .hw_reset_n_o(hw_reset_n), .sleep_out_o(sleep_out));
    drfs_top #(.LOAD_CYC(LOAD), .BLANK_CYC(BLANK)) uut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hw_reset_n_i(hw_reset_n),
        .sleep_out_i(sleep_out), .nvm_data_i(NVM), .nvm_addr_o(nvm_addr),
        .nvm_rd_o(nvm_rd), .regs_o(regs), .blank_o(blank), .blank_seq_o(blank_seq),
        .defaults_o(defaults), .ready_o(ready), .in_reset_o(in_reset));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bounded wait; no command before ready
    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 5000) begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_glitch();
        int r;
        r = rst_rises;
        host.drive(1'b0, 999, 1'b0);
        host.drive(1'b1, 1100, 1'b0);
        chk("glitch rises", rst_rises, r);
    endtask
    task automatic t_sleep_in();
        int r, s, n;
        r = rst_rises;
        s = seq_rises;
        host.drive(1'b0, 2000, 1'b0);
        chk("in_reset", in_reset, 1);
        chk("blank", blank, 1);
        chk("regs held", regs, 0);
        chk("defaults on", defaults, 1);
        host.drive(1'b1, 10, 1'b0);
        host.drive(1'b0, 1200, 1'b0);
        chk("spike rises", rst_rises, r + 1);
        chk("spike in_reset", in_reset, 1);
        chk("no blank seq", seq_rises, s);
        r = rd_cnt;
        host.drive(1'b1, 1, 1'b0);
        wait_ready(n);
        chk("load time", n <= drfs_pkg::REJECT_CYC + LOAD + 8, 1);
        chk("nvm reads", rd_cnt, r + 4);
        chk("regs loaded", regs, NVM);
        chk("unblank", blank, 0);
        chk("defaults off", defaults, 0);
        chk("nvm addr", addr_bad, 0);
    endtask
    task automatic t_sleep_out();
        int n;
        host.drive(1'b0, 1010, 1'b1);
        chk("blank seq on", blank_seq, 1);
        chk("blank on", blank, 1);
        host.drive(1'b0, BLANK + 5, 1'b1);
        chk("blank seq end", blank_seq, 0);
        chk("regs cleared", regs, 0);
        chk("defaults seq", defaults, 1);
        host.drive(1'b0, 1000, 1'b1);
        host.drive(1'b1, 1, 1'b1);
        wait_ready(n);
        chk("cancel time", n <= drfs_pkg::REJECT_CYC + LOAD + 8, 1);
        chk("regs again", regs, NVM);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge ref_clk_i);
        rst_i = 1'b0;
        @(negedge ref_clk_i);
        chk("ready rst", ready, 1);
        chk("regs rst", regs, 0);
        t_glitch();
        t_sleep_in();
        t_sleep_out();
        report_and_stop();
    end
    // Whole run is near 9400 cycles; allow about four times that
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule // tb_drfs_top
